// ### pkg/uart_tx_map.svh
`ifndef UART_TX_MAP_SVH
`define UART_TX_MAP_SVH
`define IDX_INT_FLAGS   8'h0c
`define IDX_RX_CTRL     8'h18
`define IDX_TX_HOLD     8'h19
`define IDX_PIN_DIR     8'h87
`define IDX_INT_EN      8'h8c
`define IDX_TX_CTRL     8'h98
`define IDX_BAUD_DIV    8'h99
`define TXC_NINE        6
`define TXC_ENABLE      5
`define TXC_SYNC        4
`define TXC_HIGH_SPEED  2
`define TXC_SHIFT_EMPTY 1
`define TXC_NINTH       0
`define TXC_WR_MASK     8'hf5
`define RXC_PORT_EN     7
`define RXC_SINGLE_RX   5
`define RXC_CONT_RX     4
`define RXC_WR_MASK     8'hf0
`define FLG_TX_EMPTY    4
`define EN_TX_EMPTY     4
`define DIR_TX_PIN      6
`define DIR_RX_PIN      7
`define RST_TX_CTRL     8'h02
`define RST_RX_CTRL     8'h00
`define RST_BYTE        8'h00
`define RST_PIN_DIR     8'hff
`define PRE_SYNC        7'h04
`define PRE_HIGH        7'h10
`define PRE_LOW         7'h40
`define LINE_IDLE       1'b1
`define LINE_START      1'b0
`define FRAME_LEN_8     4'ha
`define FRAME_LEN_9     4'hb
`endif

// ### pkg/uart_tx_pkg.sv
package uart_tx_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_ARMED, TX_SHIFT} tx_state_t;
    typedef logic [7:0] byte_t;
endpackage

// ### pkg/serial_core_if.sv
interface serial_core_if #(parameter int DIV_W = 8);
    logic             run;
    logic             clearTimer;
    logic             highSpeed;
    logic             syncMode;
    logic [DIV_W-1:0] divisor;
    logic             bitTick;
    logic             load;
    logic             abort;
    logic             nineBit;
    logic [8:0]       frameData;
    logic             busy;
    logic             txLine;
    modport brg     (input run, clearTimer, highSpeed, syncMode, divisor, output bitTick);
    modport shifter (input bitTick, load, abort, nineBit, frameData, output busy, txLine);
    modport ctrl    (output run, clearTimer, highSpeed, syncMode, divisor, load, abort,
                     nineBit, frameData, input bitTick, busy, txLine);
endinterface

// ### design/baud_gen.sv
`include "uart_tx_map.svh"
module baud_gen #(parameter int DIV_W = 8) (
    input  wire logic  clk,
    input  wire logic  resetn,
    serial_core_if.brg bus
);
    logic [DIV_W-1:0] timer_r;
    logic [6:0]       pre_r;
    logic             bitTick_r;

    // One divisor, one ratio choice: receiver would share this same tick source
    function automatic logic [6:0] ratio(input logic syncMode, input logic highSpeed);
        if (syncMode)
            ratio = `PRE_SYNC;
        else if (highSpeed)
            ratio = `PRE_HIGH;
        else
            ratio = `PRE_LOW;
    endfunction

    always_ff @(posedge clk) begin
        if (!resetn || !bus.run || bus.clearTimer) begin
            timer_r   <= '0;
            pre_r     <= '0;
            bitTick_r <= 1'b0;
        end else if (timer_r == bus.divisor) begin
            timer_r <= '0;
            if (pre_r == ratio(bus.syncMode, bus.highSpeed) - 7'h01) begin
                pre_r     <= '0;
                bitTick_r <= 1'b1;
            end else begin
                pre_r     <= pre_r + 7'h01;
                bitTick_r <= 1'b0;
            end
        end else begin
            timer_r   <= timer_r + 1'b1;
            bitTick_r <= 1'b0;
        end
    end

    assign bus.bitTick = bitTick_r;
endmodule

// ### design/tx_shifter.sv
`include "uart_tx_map.svh"
module tx_shifter (
    input  wire logic      clk,
    input  wire logic      resetn,
    serial_core_if.shifter bus
);
    uart_tx_pkg::tx_state_t state_r;
    logic [10:0]            shreg_r;
    logic [3:0]             left_r;
    logic [3:0]             len_r;
    logic                   line_r;

    always_ff @(posedge clk) begin
        if (!resetn || bus.abort) begin
            state_r <= uart_tx_pkg::TX_IDLE;
            shreg_r <= '1;
            left_r  <= '0;
            len_r   <= `FRAME_LEN_8;
            line_r  <= `LINE_IDLE;
        end else begin
            case (state_r)
                uart_tx_pkg::TX_IDLE: begin
                    line_r <= `LINE_IDLE;
                    if (bus.load) begin
                        // Unused ninth slot carries stop level, so both lengths share one path
                        shreg_r <= {`LINE_IDLE, bus.nineBit ? bus.frameData[8] : `LINE_IDLE,
                                    bus.frameData[7:0], `LINE_START};
                        len_r   <= bus.nineBit ? `FRAME_LEN_9 : `FRAME_LEN_8;
                        state_r <= uart_tx_pkg::TX_ARMED;
                    end
                end
                uart_tx_pkg::TX_ARMED: begin
                    if (bus.bitTick) begin
                        line_r  <= shreg_r[0];
                        shreg_r <= {`LINE_IDLE, shreg_r[10:1]};
                        left_r  <= len_r - 4'h1;
                        state_r <= uart_tx_pkg::TX_SHIFT;
                    end
                end
                uart_tx_pkg::TX_SHIFT: begin
                    if (bus.bitTick) begin
                        if (left_r == 4'h0) begin
                            state_r <= uart_tx_pkg::TX_IDLE;
                            line_r  <= `LINE_IDLE;
                        end else begin
                            line_r  <= shreg_r[0];
                            shreg_r <= {`LINE_IDLE, shreg_r[10:1]};
                            left_r  <= left_r - 4'h1;
                        end
                    end
                end
                default: state_r <= uart_tx_pkg::TX_IDLE;
            endcase
        end
    end

    assign bus.busy   = (state_r != uart_tx_pkg::TX_IDLE);
    assign bus.txLine = line_r;
endmodule

// ### design/uart_tx_top.sv
// Decided for this implementation: register access over APB.
`include "uart_tx_map.svh"
module uart_tx_top #(
    parameter int AW    = 12,
    parameter int DIV_W = 8
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [AW-1:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleepReq,
    output logic             txOut,
    output logic             txOe,
    output logic             txIntReq
);
    generate
        if (AW < 10 || DIV_W < 1 || DIV_W > 8)
            $error("uart_tx_top: AW must be at least 10 and DIV_W within 1..8");
    endgenerate

    serial_core_if #(.DIV_W(DIV_W)) core ();

    baud_gen #(.DIV_W(DIV_W)) u_brg (
        .clk    (clk),
        .resetn (resetn),
        .bus    (core.brg)
    );

    tx_shifter u_shift (
        .clk    (clk),
        .resetn (resetn),
        .bus    (core.shifter)
    );

    uart_tx_pkg::byte_t txCtrl_r;
    uart_tx_pkg::byte_t rxCtrl_r;
    uart_tx_pkg::byte_t intEn_r;
    uart_tx_pkg::byte_t pinDir_r;
    uart_tx_pkg::byte_t holdData_r;
    logic [DIV_W-1:0]   baudDiv_r;
    logic               holdFull_r;
    logic               tx_buffer_empty_flag_r;
    logic [31:0]        prdata_r;
    logic               pready_r;
    logic               pslverr_r;
    logic               txOut_r;
    logic               txOe_r;
    logic               txIntReq_r;

    // Word-aligned register hit; indices are byte address divided by four
    function automatic logic hit(input logic [AW-1:0] addr, input logic [7:0] idx);
        hit = (addr[1:0] == 2'b00) && (addr[AW-1:2] == {{(AW-10){1'b0}}, idx});
    endfunction

    function automatic logic mapped(input logic [AW-1:0] addr);
        mapped = hit(addr, `IDX_INT_FLAGS) || hit(addr, `IDX_RX_CTRL)
              || hit(addr, `IDX_TX_HOLD) || hit(addr, `IDX_PIN_DIR)
              || hit(addr, `IDX_INT_EN) || hit(addr, `IDX_TX_CTRL)
              || hit(addr, `IDX_BAUD_DIV);
    endfunction

    logic setupPhase;
    logic wrFire;
    logic wrTxCtrl;
    logic wrHold;
    logic wrBaud;
    logic txEnable;
    logic portEnable;
    logic xmitActive;
    logic transfer;
    logic enableRise;

    assign setupPhase = psel && !penable;
    // Writes land only at the completing edge and only through byte lane 0
    assign wrFire     = psel && penable && pready_r && pwrite && !pslverr_r && pstrb[0];
    assign wrTxCtrl   = wrFire && hit(paddr, `IDX_TX_CTRL);
    assign wrHold     = wrFire && hit(paddr, `IDX_TX_HOLD);
    assign wrBaud     = wrFire && hit(paddr, `IDX_BAUD_DIV);

    assign txEnable   = txCtrl_r[`TXC_ENABLE];
    assign portEnable = rxCtrl_r[`RXC_PORT_EN];
    assign xmitActive = txEnable && portEnable && !txCtrl_r[`TXC_SYNC];
    assign enableRise = wrTxCtrl && pwdata[`TXC_ENABLE] && !txEnable;
    // Sleep freezes the hand-over as well as the baud ticks
    assign transfer   = xmitActive && holdFull_r && !core.busy && !sleepReq;

    // Baud generator runs whenever either direction wants it and sleepReq is low, as the receiver would
    assign core.run        = (txEnable || rxCtrl_r[`RXC_CONT_RX] || rxCtrl_r[`RXC_SINGLE_RX])
                             && !sleepReq;
    assign core.clearTimer = wrBaud;
    assign core.highSpeed  = txCtrl_r[`TXC_HIGH_SPEED];
    assign core.syncMode   = txCtrl_r[`TXC_SYNC];
    assign core.divisor    = baudDiv_r;
    assign core.load       = transfer;
    assign core.abort      = !xmitActive;
    assign core.nineBit    = txCtrl_r[`TXC_NINE];
    assign core.frameData  = {txCtrl_r[`TXC_NINTH], holdData_r};

    // APB answers with one wait-free access cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setupPhase;
            pslverr_r <= setupPhase && !mapped(paddr);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata_r <= '0;
        end else if (setupPhase && !pwrite) begin
            prdata_r <= '0;
            if (hit(paddr, `IDX_INT_FLAGS))
                prdata_r[`FLG_TX_EMPTY] <= tx_buffer_empty_flag_r;
            else if (hit(paddr, `IDX_RX_CTRL))
                prdata_r[7:0] <= rxCtrl_r;
            else if (hit(paddr, `IDX_TX_HOLD))
                prdata_r[7:0] <= holdData_r;
            else if (hit(paddr, `IDX_PIN_DIR))
                prdata_r[7:0] <= pinDir_r;
            else if (hit(paddr, `IDX_INT_EN))
                prdata_r[7:0] <= intEn_r;
            else if (hit(paddr, `IDX_TX_CTRL)) begin
                prdata_r[7:0]              <= txCtrl_r;
                prdata_r[`TXC_SHIFT_EMPTY] <= !core.busy;
            end else if (hit(paddr, `IDX_BAUD_DIV))
                prdata_r[DIV_W-1:0] <= baudDiv_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            txCtrl_r  <= `RST_TX_CTRL & `TXC_WR_MASK;
            rxCtrl_r  <= `RST_RX_CTRL;
            intEn_r   <= `RST_BYTE;
            pinDir_r  <= `RST_PIN_DIR;
            baudDiv_r <= '0;
        end else if (wrFire) begin
            if (hit(paddr, `IDX_TX_CTRL))
                txCtrl_r <= pwdata[7:0] & `TXC_WR_MASK;
            if (hit(paddr, `IDX_RX_CTRL))
                rxCtrl_r <= pwdata[7:0] & `RXC_WR_MASK;
            if (hit(paddr, `IDX_INT_EN))
                intEn_r <= pwdata[7:0];
            if (hit(paddr, `IDX_PIN_DIR))
                pinDir_r <= pwdata[7:0];
            if (hit(paddr, `IDX_BAUD_DIV))
                baudDiv_r <= pwdata[DIV_W-1:0];
        end
    end

    // Holding register survives an abort so write-then-enable still starts
    always_ff @(posedge clk) begin
        if (!resetn) begin
            holdData_r <= `RST_BYTE;
            holdFull_r <= 1'b0;
        end else begin
            if (wrHold)
                holdData_r <= pwdata[7:0];
            if (wrHold)
                holdFull_r <= 1'b1;
            else if (transfer)
                holdFull_r <= 1'b0;
        end
    end

    // Set beats clear; flags register writes cannot touch it
    always_ff @(posedge clk) begin
        if (!resetn)
            tx_buffer_empty_flag_r <= 1'b0;
        else if (transfer || enableRise)
            tx_buffer_empty_flag_r <= 1'b1;
        else if (wrHold)
            tx_buffer_empty_flag_r <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!resetn)
            txIntReq_r <= 1'b0;
        else
            txIntReq_r <= tx_buffer_empty_flag_r && intEn_r[`EN_TX_EMPTY];
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            txOut_r <= `LINE_IDLE;
            txOe_r  <= 1'b0;
        end else begin
            txOe_r  <= xmitActive && pinDir_r[`DIR_TX_PIN] && pinDir_r[`DIR_RX_PIN];
            txOut_r <= xmitActive ? core.txLine : `LINE_IDLE;
        end
    end

    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign txOut    = txOut_r;
    assign txOe     = txOe_r;
    assign txIntReq = txIntReq_r;
endmodule

// ### bench/uart_tx_checker.sv
module uart_tx_checker (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleepReq,
    input wire logic        txOut,
    input wire logic        txOe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_setup_answer: assert property (psel && !penable |=> pready)
        else $error("setup not answered");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready too long");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_float_idle: assert property (!txOe |-> txOut)
        else $error("line low while released");
    chk_start_driven: assert property ($fell(txOut) |-> txOe)
        else $error("start bit while released");
    chk_start_len: assert property ($fell(txOut) |=> !txOut [*8])
        else $error("start bit too short");
    chk_sleep_freeze: assert property (sleepReq [*3] |-> $stable(txOut))
        else $error("line moved in sleep");
    cover property ($fell(txOut));
    cover property (pslverr);
    cover property ($fell(txOe));
    cover property (sleepReq [*3]);
endmodule

// ### bench/serial_rx_model.sv
module serial_rx_model (
    input  wire logic       clk,
    input  wire logic       line,
    input  wire logic       nine,
    input  int              period,
    output logic      [8:0] word,
    output logic            framingOk,
    output int              frames
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] acc;
    initial begin
        word = 9'h000;
        framingOk = 1'b1;
        frames = 0;
        forever begin
            @(negedge line);
            // Sample mid-bit to ride out edge jitter
            repeat (period / 2) @(posedge clk);
            acc = 9'h000;
            for (int b = 0; b < (nine ? 9 : 8); b++) begin
                repeat (period) @(posedge clk);
                acc[b] = line;
            end
            repeat (period) @(posedge clk);
            framingOk = framingOk & line;
            word = acc;
            frames = frames + 1;
        end
    end
endmodule

// ### bench/tb.sv
`include "uart_tx_map.svh"
bind uart_tx_top uart_tx_checker chk (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleepReq(sleepReq), .txOut(txOut), .txOe(txOe));
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, resetn, psel, penable, pwrite, sleepReq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, txOut, txOe, txIntReq, err, nine, stopOk;
    logic [8:0]  rxWord;
    int          bad_count, n_tests, rxFrames, period;
    // Pull-up: a released pin reads high
    wire         line = txOe ? txOut : 1'b1;
    uart_tx_top uut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleepReq(sleepReq), .txOut(txOut),
        .txOe(txOe), .txIntReq(txIntReq));
    serial_rx_model far (.clk(clk), .line(line), .nine(nine), .period(period),
        .word(rxWord), .framingOk(stopOk), .frames(rxFrames));
    initial clk = 1'b0;
    always #20 clk = ~clk;
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask
    task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
        int n;
        paddr <= {2'b00, idx, 2'b00};
        pwrite <= w;
        pwdata <= {24'h0, d};
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            $display("ERROR apb answer expected %0d cycles seen %0d", 20, n);
            bad_count++;
            close_out();
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        apb(idx, 1'b0, 8'h00);
        check(nm, exp, rd);
    endtask
    task automatic frame(input int tgt, input logic [8:0] exp);
        int n;
        n = 0;
        while (rxFrames < tgt && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000) begin
            $display("ERROR frame count expected %0d seen %0d", tgt, rxFrames);
            bad_count++;
            close_out();
        end
        check("frame", {23'h0, exp}, {23'h0, rxWord});
    endtask
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sleepReq = 1'b0;
        nine = 1'b0;
        period = 16;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rchk("tx ctrl", `IDX_TX_CTRL, 32'h02);
        rchk("flags", `IDX_INT_FLAGS, 32'h00);
        rchk("divisor", `IDX_BAUD_DIV, 32'h00);
        rchk("pin dir", `IDX_PIN_DIR, 32'hff);
        apb(8'h01, 1'b0, 8'h00);
        check("unmapped", 32'h1, {31'h0, err});
        apb(`IDX_BAUD_DIV, 1'b1, 8'h00);
        apb(`IDX_RX_CTRL, 1'b1, 8'h80);
        apb(`IDX_INT_EN, 1'b1, 8'h10);
        apb(`IDX_TX_CTRL, 1'b1, 8'h24);
        rchk("flag on enable", `IDX_INT_FLAGS, 32'h10);
        check("irq", 32'h1, {31'h0, txIntReq});
        apb(`IDX_INT_FLAGS, 1'b1, 8'h00);
        rchk("flag kept", `IDX_INT_FLAGS, 32'h10);
        apb(`IDX_TX_HOLD, 1'b1, 8'ha5);
        rchk("flag after move", `IDX_INT_FLAGS, 32'h10);
        rchk("shift busy", `IDX_TX_CTRL, 32'h24);
        apb(`IDX_TX_HOLD, 1'b1, 8'h3c);
        rchk("flag full", `IDX_INT_FLAGS, 32'h00);
        check("irq off", 32'h0, {31'h0, txIntReq});
        frame(1, 9'h0a5);
        frame(2, 9'h03c);
        period = 32;
        nine = 1'b1;
        apb(`IDX_BAUD_DIV, 1'b1, 8'h01);
        apb(`IDX_TX_CTRL, 1'b1, 8'h65);
        apb(`IDX_TX_HOLD, 1'b1, 8'h81);
        frame(3, 9'h181);
        period = 64;
        nine = 1'b0;
        apb(`IDX_TX_CTRL, 1'b1, 8'h00);
        apb(`IDX_BAUD_DIV, 1'b1, 8'h00);
        apb(`IDX_TX_HOLD, 1'b1, 8'h5a);
        sleepReq <= 1'b1;
        apb(`IDX_TX_CTRL, 1'b1, 8'h20);
        repeat (200) @(posedge clk);
        check("sleep", 32'h3, rxFrames);
        sleepReq <= 1'b0;
        frame(4, 9'h05a);
        check("stop bits", 32'h1, {31'h0, stopOk});
        apb(`IDX_TX_CTRL, 1'b1, 8'h34);
        apb(`IDX_TX_HOLD, 1'b1, 8'hff);
        check("sync off", 32'h0, {31'h0, txOe});
        period = 16;
        apb(`IDX_TX_CTRL, 1'b1, 8'h24);
        repeat (40) @(posedge clk);
        apb(`IDX_TX_CTRL, 1'b1, 8'h04);
        // Output enable is registered one edge after the write lands
        @(posedge clk);
        check("abort", 32'h0, {31'h0, txOe});
        rchk("abort empty", `IDX_TX_CTRL, 32'h06);
        apb(`IDX_PIN_DIR, 1'b1, 8'h3f);
        apb(`IDX_TX_CTRL, 1'b1, 8'h24);
        @(posedge clk);
        check("pin dir off", 32'h0, {31'h0, txOe});
        apb(`IDX_PIN_DIR, 1'b1, 8'hff);
        @(posedge clk);
        check("pin dir on", 32'h1, {31'h0, txOe});
        close_out();
    end
endmodule
